/* File: hw/reset_state_initialiser.sv */
/*
 * Reset-state initialiser: picks the reset kind, keeps the timeout and
 * power-down flags, holds the core and issues the initial-condition strobes.
 * Assumes a 100 MHz clock, an Avalon-MM master with waitrequest, and a core
 * that reports idle/sleep on sleep_mode from the same clock domain.
 */
// Decided for this implementation: the address map and the Avalon-MM register port.
// Summary of operation
// - a watchdog timeout in idle or sleep zeroes pc and sp, sets the timeout and power-down flags, keeps the rest.
// - the timeout and power-down flags live in the status register and clear on power-on.
// - a low-voltage reset in fast or slow mode leaves both flags as they were.
// - a watchdog timeout in fast or slow mode sets the timeout flag and keeps power-down.
// - a watchdog timeout in idle or sleep sets both the timeout and power-down flags.
// - after power-on every interrupt source is disabled.
// - after power-on the watchdog and time bases are cleared and the watchdog counts at once.
// - after power-on every timer module is switched off.
// - after power-on every port pin is an input.
// - after power-on the pc is zero and the sp points to the top of the stack.
// - peripheral registers take power-on values except on a sleep watchdog timeout.
// - a watchdog timeout in normal operation acts like a low-voltage reset plus the flag.
// - a control code other than the two valid patterns resets the device after a delay.
module reset_state_initialiser #(
    parameter int unsigned WDT_CYC = rst_init_pkg::WDT_CYC_DEF,
    parameter int unsigned TB_CYC = rst_init_pkg::TB_CYC_DEF,
    parameter int unsigned SRESET_CYC = rst_init_pkg::SRESET_CYC
) (
    input wire logic clk, // system clock, 100 MHz
    input wire logic arst_n, // power-on reset, active low, asynchronous
    input wire logic low_voltage_reset, // supply-low detector output, asynchronous level
    input wire logic sleep_mode, // core is in idle or sleep
    input wire logic wdt_kick, // core clears the watchdog
    input wire logic [7:0] address, // avalon byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [3:0] byteenable, // avalon byte enables
    input wire logic [31:0] writedata, // avalon write data
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest, // avalon wait
    output logic irq, // level interrupt
    output logic core_hold, // core held in reset
    output logic pc_clear, // load program counter with zero
    output logic sp_load, // load stack pointer with sp_value
    output logic [4:0] sp_value, // stack pointer initial value
    output logic periph_init, // peripheral registers to power-on values
    output logic int_disable, // clear all interrupt enables
    output logic timers_off, // switch every timer module off
    output logic ports_input, // set every port pin to input
    output logic watchdog_timeout_flag, // timeout flag
    output logic power_down_flag // power-down flag
);
    logic rst_s1_ff;
    logic rst_n;
    logic lvr_s1_ff;
    logic lvr_s2_ff;
    logic lvr_q_ff;
    logic lvr_evt;
    logic wdt_run_evt;
    logic wdt_sleep_evt;
    logic code_bad;
    logic start;
    rst_init_pkg::reset_kind_t nxt_kind;
    rst_init_pkg::state_t state_ff;
    rst_init_pkg::reset_kind_t kind_ff;
    logic [31:0] cnt_ff;
    logic to_ff;
    logic pdf_ff;
    logic [7:0] code_ff;
    logic full_ff;
    logic strobe_ff;
    logic [rst_init_pkg::EVT_W-1:0] evt_stat_ff;
    logic [rst_init_pkg::EVT_W-1:0] evt_en_ff;
    logic [rst_init_pkg::EVT_W-1:0] evt_set;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic wr_go;
    logic rd_go;

    wdt_ctl_if wdt_bus ();

    wdt_timebase #(
        .WDT_CYC(WDT_CYC),
        .TB_CYC(TB_CYC)
    ) u_wdt (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(wdt_bus)
    );

    function automatic logic code_valid(input logic [7:0] c);
        return (c == rst_init_pkg::CODE_POR) || (c == rst_init_pkg::CODE_ALT);
    endfunction

    // reset released through two flops so every flop leaves reset on one edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n <= rst_s1_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvr_s1_ff <= 1'b0;
            lvr_s2_ff <= 1'b0;
            lvr_q_ff <= 1'b0;
        end else begin
            lvr_s1_ff <= low_voltage_reset;
            lvr_s2_ff <= lvr_s1_ff;
            lvr_q_ff <= lvr_s2_ff;
        end
    end

    // the low-voltage detector is off in idle and sleep
    assign lvr_evt = lvr_s2_ff && !lvr_q_ff && !sleep_mode;
    assign wdt_run_evt = wdt_bus.timeout && !sleep_mode;
    assign wdt_sleep_evt = wdt_bus.timeout && sleep_mode;
    assign code_bad = !code_valid(code_ff);
    assign start = (state_ff != rst_init_pkg::S_HOLD) &&
        (lvr_evt || wdt_bus.timeout ||
        (state_ff == rst_init_pkg::S_SW_WAIT && cnt_ff == 32'h0000_0000));

    // low voltage outranks the watchdog; the software delay comes last
    always_comb begin
        if (lvr_evt) begin
            nxt_kind = rst_init_pkg::K_LVR;
        end else if (wdt_sleep_evt) begin
            nxt_kind = rst_init_pkg::K_WDT_SLEEP;
        end else if (wdt_run_evt) begin
            nxt_kind = rst_init_pkg::K_WDT_RUN;
        end else begin
            nxt_kind = rst_init_pkg::K_SW;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= rst_init_pkg::S_HOLD;
            kind_ff <= rst_init_pkg::K_POR;
            cnt_ff <= 32'(rst_init_pkg::HOLD_CYC - 1);
        end else begin
            unique case (state_ff)
                rst_init_pkg::S_RUN: begin
                    if (start) begin
                        state_ff <= rst_init_pkg::S_HOLD;
                        kind_ff <= nxt_kind;
                        cnt_ff <= 32'(rst_init_pkg::HOLD_CYC - 1);
                    end else if (code_bad) begin
                        state_ff <= rst_init_pkg::S_SW_WAIT;
                        cnt_ff <= 32'(SRESET_CYC - 1);
                    end
                end
                rst_init_pkg::S_SW_WAIT: begin
                    if (start) begin
                        state_ff <= rst_init_pkg::S_HOLD;
                        kind_ff <= nxt_kind;
                        cnt_ff <= 32'(rst_init_pkg::HOLD_CYC - 1);
                    end else begin
                        cnt_ff <= cnt_ff - 32'h0000_0001;
                    end
                end
                rst_init_pkg::S_HOLD: begin
                    if (cnt_ff == 32'h0000_0000) begin
                        state_ff <= rst_init_pkg::S_RUN;
                    end else begin
                        cnt_ff <= cnt_ff - 32'h0000_0001;
                    end
                end
                default: begin
                    state_ff <= rst_init_pkg::S_HOLD;
                    kind_ff <= rst_init_pkg::K_POR;
                    cnt_ff <= 32'(rst_init_pkg::HOLD_CYC - 1);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            to_ff <= 1'b0;
            pdf_ff <= 1'b0;
        end else if (start && wdt_sleep_evt && !lvr_evt) begin
            to_ff <= 1'b1;
            pdf_ff <= 1'b1;
        end else if (start && wdt_run_evt && !lvr_evt) begin
            to_ff <= 1'b1;
        end
        // low-voltage and software resets keep both flags
    end

    // strobes stand high through power-on reset and for one cycle after other starts; full_ff stays low after a sleep timeout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_ff <= 1'b1;
            full_ff <= 1'b1;
        end else begin
            strobe_ff <= start;
            full_ff <= start && (nxt_kind != rst_init_pkg::K_WDT_SLEEP);
        end
    end

    // a sleep timeout keeps the control code; every other reset restores it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= rst_init_pkg::CODE_POR;
        end else if (start && nxt_kind != rst_init_pkg::K_WDT_SLEEP) begin
            code_ff <= rst_init_pkg::CODE_POR;
        end else if (wr_go && address == rst_init_pkg::OFS_RST_CODE && byteenable[0]) begin
            code_ff <= writedata[7:0];
        end
    end

    assign evt_set[rst_init_pkg::EVT_LVR] = start && nxt_kind == rst_init_pkg::K_LVR;
    assign evt_set[rst_init_pkg::EVT_WDT_RUN] = start && nxt_kind == rst_init_pkg::K_WDT_RUN;
    assign evt_set[rst_init_pkg::EVT_WDT_SLEEP] = start && nxt_kind == rst_init_pkg::K_WDT_SLEEP;
    assign evt_set[rst_init_pkg::EVT_SW] = start && nxt_kind == rst_init_pkg::K_SW;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_stat_ff <= 4'h0;
        end else if (wr_go && address == rst_init_pkg::OFS_EVT_CLR && byteenable[0]) begin
            evt_stat_ff <= (evt_stat_ff & ~writedata[rst_init_pkg::EVT_W-1:0]) | evt_set;
        end else begin
            evt_stat_ff <= evt_stat_ff | evt_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_en_ff <= 4'h0;
        end else if (wr_go && address == rst_init_pkg::OFS_EVT_EN && byteenable[0]) begin
            evt_en_ff <= writedata[rst_init_pkg::EVT_W-1:0];
        end
    end

    // one wait cycle per access: request seen, acknowledged on the next edge
    assign wr_go = write && ack_ff;
    assign rd_go = read && ack_ff;
    assign waitrequest = (read || write) && !ack_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (read || write) && !ack_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (read && !ack_ff) begin
            unique case (address)
                rst_init_pkg::OFS_STATUS: begin
                    rdata_ff <= {28'h000_0000, state_ff == rst_init_pkg::S_HOLD,
                        sleep_mode, pdf_ff, to_ff};
                end
                rst_init_pkg::OFS_RST_CODE: begin
                    rdata_ff <= {24'h00_0000, code_ff};
                end
                rst_init_pkg::OFS_EVT_STAT: begin
                    rdata_ff <= {28'h000_0000, evt_stat_ff};
                end
                rst_init_pkg::OFS_EVT_EN: begin
                    rdata_ff <= {28'h000_0000, evt_en_ff};
                end
                default: begin
                    rdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign readdata = rd_go ? rdata_ff : 32'h0000_0000;
    assign irq = |(evt_stat_ff & evt_en_ff);

    // watchdog restarts with every reset so it counts from zero at once
    assign wdt_bus.clear = strobe_ff;
    assign wdt_bus.kick = wdt_kick && !core_hold;

    assign core_hold = (state_ff == rst_init_pkg::S_HOLD);
    assign pc_clear = strobe_ff;
    assign sp_load = strobe_ff;
    assign sp_value = rst_init_pkg::SP_TOP;
    assign periph_init = full_ff;
    assign int_disable = full_ff;
    assign timers_off = full_ff;
    assign ports_input = full_ff;
    assign watchdog_timeout_flag = to_ff;
    assign power_down_flag = pdf_ff;
endmodule

/* File: hw/rst_init_pkg.sv */
/*
 * Constants shared by the reset-state initialiser and its watchdog/time-base
 * counter: register offsets, field positions, reset values, timing and states.
 * Assumes a 100 MHz system clock.
 */
package rst_init_pkg;

    localparam int unsigned CLK_MHZ = 100;

    // register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_RST_CODE = 8'h04;
    localparam logic [7:0] OFS_EVT_STAT = 8'h08;
    localparam logic [7:0] OFS_EVT_CLR = 8'h0c;
    localparam logic [7:0] OFS_EVT_EN = 8'h10;

    // status register fields
    localparam int unsigned BIT_TIMEOUT = 0;
    localparam int unsigned BIT_POWER_DOWN = 1;
    localparam int unsigned BIT_SLEEP = 2;
    localparam int unsigned BIT_HOLD = 3;

    // event bits (status, clear and enable share this layout)
    localparam int unsigned EVT_W = 4;
    localparam int unsigned EVT_LVR = 0;
    localparam int unsigned EVT_WDT_RUN = 1;
    localparam int unsigned EVT_WDT_SLEEP = 2;
    localparam int unsigned EVT_SW = 3;

    // software reset control code: two patterns mean no operation
    localparam logic [7:0] CODE_POR = 8'h55;
    localparam logic [7:0] CODE_ALT = 8'haa;

    // stack pointer value at the top of the stack
    localparam logic [4:0] SP_TOP = 5'h00;

    // delay before a bad control code resets the device
    localparam int unsigned SRESET_NS = 1000;
    localparam int unsigned SRESET_CYC = (SRESET_NS * CLK_MHZ) / 1000;
    // core hold time after any reset
    localparam int unsigned HOLD_NS = 100;
    localparam int unsigned HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W = 16;

    localparam int unsigned WDT_CYC_DEF = 65536;
    localparam int unsigned TB_CYC_DEF = 1024;

    typedef enum logic [1:0] {
        S_RUN = 2'b00,
        S_SW_WAIT = 2'b01,
        S_HOLD = 2'b11
    } state_t;

    typedef enum logic [2:0] {
        K_POR = 3'h0,
        K_LVR = 3'h1,
        K_WDT_RUN = 3'h2,
        K_WDT_SLEEP = 3'h3,
        K_SW = 3'h4
    } reset_kind_t;

endpackage

/* File: hw/wdt_ctl_if.sv */
/*
 * Signals between the reset sequencer and the watchdog/time-base counter.
 * Assumes both ends run on the same clock.
 */
interface wdt_ctl_if;
    logic clear;
    logic kick;
    logic timeout;
    logic tb_tick;
    logic [15:0] wdt_count;

    modport seq (output clear, output kick, input timeout, input tb_tick, input wdt_count);
    modport cnt (input clear, input kick, output timeout, output tb_tick, output wdt_count);
endinterface

/* File: hw/wdt_timebase.sv */
/*
 * Watchdog counter and time-base counter. Both are cleared by the sequencer
 * and start counting on the next edge. Assumes an active-low reset that asserts asynchronously and releases on an edge.
 */
module wdt_timebase #(
    parameter int unsigned WDT_CYC = 65536,
    parameter int unsigned TB_CYC = 1024
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    wdt_ctl_if.cnt ctl // clear, kick and timeout
);
    logic [31:0] wdt_ff;
    logic [31:0] tb_ff;
    logic timeout_ff;
    logic tick_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_ff <= 32'h0000_0000;
            timeout_ff <= 1'b0;
        end else if (ctl.clear || ctl.kick) begin
            wdt_ff <= 32'h0000_0000;
            timeout_ff <= 1'b0;
        end else if (wdt_ff == 32'(WDT_CYC - 1)) begin
            wdt_ff <= 32'h0000_0000;
            timeout_ff <= 1'b1;
        end else begin
            wdt_ff <= wdt_ff + 32'h0000_0001;
            timeout_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (ctl.clear) begin
            tb_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (tb_ff == 32'(TB_CYC - 1)) begin
            tb_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            tb_ff <= tb_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    assign ctl.timeout = timeout_ff;
    assign ctl.tb_tick = tick_ff;
    assign ctl.wdt_count = wdt_ff[15:0];
endmodule

/* File: verif/reset_state_initialiser_monitor.sv */
/* checker for the reset-state initialiser: strobe and hold timing, flag
   updates, bus wait state and the bad-code delay.
   assumes it is bound to the top module and sees only its ports. */
module reset_state_initialiser_monitor #(
    parameter int unsigned SRESET_CYC = 8
) (
    input wire logic clk, // system clock
    input wire logic arst_n, // power-on reset, active low
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic waitrequest, // avalon wait
    input wire logic [7:0] address, // avalon address
    input wire logic [3:0] byteenable, // avalon byte enables
    input wire logic [31:0] writedata, // avalon write data
    input wire logic core_hold, // core held
    input wire logic pc_clear, // pc strobe
    input wire logic sp_load, // sp strobe
    input wire logic [4:0] sp_value, // initial sp
    input wire logic periph_init, // peripheral init
    input wire logic int_disable, // interrupt disable
    input wire logic timers_off, // timers off
    input wire logic ports_input, // ports to input
    input wire logic watchdog_timeout_flag, // timeout flag
    input wire logic power_down_flag // power-down flag
);
    // window allows for the code write landing and the event being taken
    localparam int SR_LO = SRESET_CYC - 1;
    localparam int SR_HI = SRESET_CYC + 3;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence start_ev;
        $rose(pc_clear);
    endsequence
    sequence hold_run;
        core_hold[*8] ##1 core_hold[*2] ##1 !core_hold;
    endsequence
    chk_hold_span: assert property (start_ev |-> hold_run)
        else $error("core hold span wrong");
    chk_strobe_once: assert property (start_ev |=> !pc_clear && !sp_load)
        else $error("strobe longer than one cycle");
    chk_pc_sp_pair: assert property (pc_clear == sp_load && sp_value == rst_init_pkg::SP_TOP)
        else $error("pc and sp strobes disagree");
    chk_init_group: assert property (start_ev |-> int_disable == periph_init &&
        timers_off == periph_init && ports_input == periph_init)
        else $error("init strobes disagree");
    chk_sleep_flags: assert property ((start_ev and !periph_init) |->
        watchdog_timeout_flag && power_down_flag)
        else $error("sleep reset flags wrong");
    chk_flags_hold: assert property (!$rose(pc_clear) |->
        $stable(watchdog_timeout_flag) && $stable(power_down_flag))
        else $error("flags moved outside a reset");
    chk_flags_rise: assert property (start_ev |->
        !$fell(watchdog_timeout_flag) && !$fell(power_down_flag))
        else $error("flag cleared by a warm reset");
    chk_hold_strobe: assert property ($rose(core_hold) |-> pc_clear && sp_load)
        else $error("hold without strobes");
    chk_bus_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus wait state wrong");
    chk_sw_delay: assert property (write && !waitrequest && byteenable[0] && !core_hold &&
        address == rst_init_pkg::OFS_RST_CODE && writedata[7:0] != rst_init_pkg::CODE_POR &&
        writedata[7:0] != rst_init_pkg::CODE_ALT |-> ##[SR_LO:SR_HI] start_ev)
        else $error("bad code reset not on time");
endmodule

bind reset_state_initialiser reset_state_initialiser_monitor #(.SRESET_CYC(SRESET_CYC)) mon_inst (
    .clk, .arst_n, .read, .write, .waitrequest, .address, .byteenable, .writedata, .core_hold,
    .pc_clear, .sp_load, .sp_value, .periph_init, .int_disable, .timers_off, .ports_input,
    .watchdog_timeout_flag, .power_down_flag);

/* File: verif/core_model.sv */
/* behavioural processor core beside the reset-state initialiser: it sleeps
   and kicks the watchdog on command and takes the initial pc and sp.
   assumes commands change right after the rising clock edge. */
module core_model (
    input wire logic clk, // system clock
    input wire logic cmd_sleep, // bench asks for idle or sleep
    input wire logic cmd_kick, // bench asks for watchdog kicks
    input wire logic core_hold, // core held in reset
    input wire logic pc_clear, // zero the pc
    input wire logic sp_load, // load the sp
    input wire logic [4:0] sp_value, // initial sp
    output logic sleep_mode = 1'b0, // idle or sleep
    output logic wdt_kick = 1'b0, // watchdog clear
    output logic [11:0] pc = 12'hfff, // program counter
    output logic [4:0] sp = 5'h1f // stack pointer, off top so a load shows
);
    // any reset wakes the core, so sleep is left while held
    always @(posedge clk) begin
        sleep_mode <= cmd_sleep && !core_hold;
        wdt_kick <= cmd_kick;
        if (pc_clear) begin
            pc <= 12'h000;
        end else if (!core_hold) begin
            pc <= pc + 12'h001;
        end
        if (sp_load) begin
            sp <= sp_value;
        end
    end
endmodule

/* File: verif/reset_state_initialiser_tb_top.sv */
/* self-checking bench for the reset-state initialiser with a core model.
   assumes a 100 MHz clock and shortened watchdog and delay counts. */
module reset_state_initialiser_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WDT = 64;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic low_voltage_reset = 1'b0, read = 1'b0, write = 1'b0, cmd_sleep = 1'b0, cmd_kick = 1'b0;
    logic [7:0] address = 8'h00;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata, q;
    logic waitrequest, irq, core_hold, pc_clear, sp_load, periph_init, int_disable, timers_off;
    logic ports_input, watchdog_timeout_flag, power_down_flag, sleep_mode, wdt_kick;
    logic [4:0] sp_value, sp;
    logic [11:0] pc;
    logic [15:0] lfsr = 16'h3b52;
    int failures = 0, compares = 0, cyc = 0, t0, n;
    logic [31:0] exp_to, exp_pd, exp_code;

    initial forever #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    reset_state_initialiser #(.WDT_CYC(WDT), .TB_CYC(16), .SRESET_CYC(8))
        reset_state_initialiser_inst (.clk, .arst_n, .low_voltage_reset, .sleep_mode, .wdt_kick,
        .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .irq,
        .core_hold, .pc_clear, .sp_load, .sp_value, .periph_init, .int_disable, .timers_off,
        .ports_input, .watchdog_timeout_flag, .power_down_flag);
    core_model core_model_inst (.clk, .cmd_sleep, .cmd_kick, .core_hold, .pc_clear, .sp_load,
        .sp_value, .sleep_mode, .wdt_kick, .pc, .sp);

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request stands until the rising edge that sees waitrequest low; data taken there
    // only the watchdog process ends a wait that never gets an answer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'h1);
        check(w, q, exp);
    endtask

    task automatic wait_start(input int lim);
        n = 0;
        while (pc_clear !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic wait_free();
        int k;
        k = 0;
        while (core_hold !== 1'b0 && k < 30) begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic evt(input int k);
        logic [31:0] m;
        m = 32'h0000_0001 << k;
        bus(1'b1, rst_init_pkg::OFS_EVT_EN, 32'h0000_0000, 4'h1);
        rd_chk("evt set", rst_init_pkg::OFS_EVT_STAT, m);
        check("irq masked", irq, 1'b0);
        bus(1'b1, rst_init_pkg::OFS_EVT_EN, m, 4'h1);
        check("irq on", irq, 1'b1);
        bus(1'b1, rst_init_pkg::OFS_EVT_CLR, m, 4'h1);
        check("irq off", irq, 1'b0);
    endtask

    task automatic took(input logic pi, input int k);
        check("start", pc_clear, 1'b1);
        check("init", {periph_init, int_disable, timers_off, ports_input}, {4{pi}});
        check("flags", {power_down_flag, watchdog_timeout_flag}, {exp_pd[0], exp_to[0]});
        @(posedge clk);
        cmd_kick <= 1'b1;
        cmd_sleep <= 1'b0;
        low_voltage_reset <= 1'b0;
        wait_free();
        check("pc sp", {pc, sp}, {12'h000, rst_init_pkg::SP_TOP});
        rd_chk("status", rst_init_pkg::OFS_STATUS, {exp_pd[0], exp_to[0]});
        rd_chk("code", rst_init_pkg::OFS_RST_CODE, exp_code);
        evt(k);
    endtask

    task automatic por();
        @(posedge clk);
        arst_n <= 1'b0;
        exp_to = 0;
        exp_pd = 0;
        exp_code = 32'h55;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("por", {pc_clear, sp_load, periph_init, int_disable, timers_off, ports_input,
            power_down_flag, watchdog_timeout_flag, core_hold}, 9'h1f9);
        @(posedge clk);
        arst_n <= 1'b1;
        t0 = cyc;
        repeat (3) @(posedge clk);
        wait_free();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        por();
        rd_chk("status", rst_init_pkg::OFS_STATUS, 32'h0000_0000);
        rd_chk("code", rst_init_pkg::OFS_RST_CODE, exp_code);
        rd_chk("unmapped", 8'h20, 32'h0000_0000);
        wait_start(WDT + 40);
        check("wdt run", (cyc - t0 >= WDT) && (cyc - t0 <= WDT + 10), 1'b1);
        exp_to = 1;
        took(1'b1, rst_init_pkg::EVT_WDT_RUN);
        bus(1'b1, rst_init_pkg::OFS_RST_CODE, 32'h0000_00aa, 4'h1);
        bus(1'b1, rst_init_pkg::OFS_RST_CODE, 32'h0000_0013, 4'h0);
        exp_code = 32'haa;
        rd_chk("code kept", rst_init_pkg::OFS_RST_CODE, exp_code);
        @(posedge clk);
        cmd_sleep <= 1'b1;
        cmd_kick <= 1'b0;
        wait_start(WDT + 40);
        exp_pd = 1;
        took(1'b0, rst_init_pkg::EVT_WDT_SLEEP);
        @(posedge clk);
        cmd_sleep <= 1'b1;
        repeat (3) @(posedge clk);
        low_voltage_reset <= 1'b1;
        wait_start(20);
        check("lvr in sleep", pc_clear, 1'b0);
        @(posedge clk);
        cmd_sleep <= 1'b0;
        low_voltage_reset <= 1'b0;
        repeat (6) @(posedge clk);
        low_voltage_reset <= 1'b1;
        wait_start(20);
        exp_code = 32'h55;
        took(1'b1, rst_init_pkg::EVT_LVR);
        do lfsr = lfsr_next(lfsr);
        while (lfsr[7:0] == 8'h55 || lfsr[7:0] == 8'haa);
        bus(1'b1, rst_init_pkg::OFS_RST_CODE, {lfsr, lfsr}, 4'h1);
        wait_start(40);
        took(1'b1, rst_init_pkg::EVT_SW);
        @(posedge clk);
        cmd_kick <= 1'b0;
        wait_start(WDT + 40);
        took(1'b1, rst_init_pkg::EVT_WDT_RUN);
        por();
        rd_chk("status", rst_init_pkg::OFS_STATUS, 32'h0000_0000);
        print_verdict();
    end
endmodule
